// file: logic/adcc_defines.svh
// constants for the conversion control block: offsets, fields, resets, timing
// assumes byte addressing on a 32-bit avalon-mm slave
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
`define ADCC_ADDR_W 4
`define ADCC_OFF_RESULT 4'h0
`define ADCC_OFF_STATUS 4'h4
`define ADCC_OFF_CTRL 4'h8
`define ADCC_OFF_START 4'hC
`define ADCC_ST_EOC 0
`define ADCC_CTRL_EXT_TRIG 7
`define ADCC_CTRL_RESET 8'h7F
`define ADCC_CTRL_UNUSED 7'h7F
`define ADCC_RESULT_W 10
`define ADCC_CONV_NS 1000
`define ADCC_CLK_NS 50
`define ADCC_CONV_CYC ((`ADCC_CONV_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_CH_W 2
`endif

// file: logic/adcc_pkg.sv
// types shared by the conversion control block
// assumes adcc_defines.svh is available
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_CONV,
    ADCC_NEXT
  } adcc_state_e;
endpackage

// file: logic/adcc_trig_sync.sv
// two-flop synchroniser and rising-edge detect for the trigger pin
// assumes the pin is asynchronous to clk_in
`timescale 1ns/1ps
module adcc_trig_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pin and event
  input wire logic pin_in,
  output logic rise_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign rise_out = sync_q & ~prev_q;
endmodule

// file: logic/adcc_top.sv
// conversion control: result, end flag, trigger enable, avalon-mm slave
// assumes an analog core that returns a sample on conv_sample_in
// Summary of operation
// [RL1] each result is held as a 10-bit value readable by software; the code keeps one register, so a scan leaves only the last channel's.
// [RL2] the end flag clears only on a zero write after software read it as 1.
// [RL3] in single mode the end flag sets when the one conversion completes.
// [RL4] in scan mode the end flag sets only after all scan channels converted.
// [RL5] writing 1 to the end flag has no effect; only a 0 write clears it.
// [RL6] with bit 7 of control at 0 the trigger pin is ignored, else it starts.
// [RL7] control bits 6 to 0 read as 1 and ignore writes.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_top #(
  parameter int CONV_CYC = `ADCC_CONV_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [`ADCC_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // converter side
  input wire logic external_trigger_pin_in,
  input wire logic [`ADCC_RESULT_W-1:0] conv_sample_in,
  output logic [`ADCC_CH_W-1:0] conv_channel_out,
  // interrupt
  output logic irq_out
);
  localparam logic [7:0] CNT_MAX = 8'(CONV_CYC - 1);
  // reset image of the control byte; only the enable bit is stored
  localparam logic [7:0] CTRL_RST = `ADCC_CTRL_RESET;
  logic trig_rise;
  adcc_trig_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(external_trigger_pin_in),
    .rise_out(trig_rise)
  );
  adcc_pkg::adcc_state_e state_q;
  logic [7:0] cnt_q;
  logic [`ADCC_CH_W-1:0] ch_q;
  logic [`ADCC_RESULT_W-1:0] result_q;
  logic conversion_end_flag_q;
  logic flag_seen_q;
  logic external_trigger_enable_q;
  logic scan_mode_q;
  logic [`ADCC_CH_W-1:0] scan_last_q;
  logic irq_mask_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic wait_q;
  // one wait state: request answered on the second edge
  wire rd_take = avs_read_in & ~ack_q;
  wire wr_take = avs_write_in & ~ack_q;
  wire wr_status = wr_take & (avs_address_in == `ADCC_OFF_STATUS);
  wire wr_ctrl = wr_take & (avs_address_in == `ADCC_OFF_CTRL);
  wire wr_start = wr_take & (avs_address_in == `ADCC_OFF_START);
  wire rd_status = rd_take & (avs_address_in == `ADCC_OFF_STATUS);
  wire sw_start = wr_start & avs_writedata_in[0];
  wire hw_start = trig_rise & external_trigger_enable_q; // [RL6]
  wire start = (state_q == adcc_pkg::ADCC_IDLE) & (sw_start | hw_start);
  wire conv_done = (state_q == adcc_pkg::ADCC_CONV) & (cnt_q == CNT_MAX);
  wire last_ch = ~scan_mode_q | (ch_q == scan_last_q);
  wire end_set = conv_done & last_ch; // [RL3] [RL4]
  wire flag_clr = wr_status & flag_seen_q &
    ~avs_writedata_in[`ADCC_ST_EOC]; // [RL2] [RL5]
  wire [31:0] ctrl_rd = {24'h0000_00,
    external_trigger_enable_q, `ADCC_CTRL_UNUSED}; // [RL7]
  logic [31:0] rd_mux;
  always_comb begin
    unique case (avs_address_in)
      `ADCC_OFF_RESULT: rd_mux = {22'h00_0000, result_q}; // [RL1]
      `ADCC_OFF_STATUS: rd_mux = {31'h0000_0000, conversion_end_flag_q};
      `ADCC_OFF_CTRL: rd_mux = ctrl_rd;
      // start bit self-clears, so it reads back as zero
      `ADCC_OFF_START: rd_mux = {27'h000_0000, scan_last_q,
        scan_mode_q, irq_mask_q, 1'b0};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // bus handshake
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= rd_take | wr_take;
      wait_q <= ~(rd_take | wr_take);
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end
  // control register; the start offset also holds mode bits
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      external_trigger_enable_q <= CTRL_RST[`ADCC_CTRL_EXT_TRIG];
      scan_mode_q <= 1'b0;
      scan_last_q <= '0;
      irq_mask_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        external_trigger_enable_q <=
          avs_writedata_in[`ADCC_CTRL_EXT_TRIG]; // [RL6] [RL7]
      end
      if (wr_start) begin
        irq_mask_q <= avs_writedata_in[1];
        scan_mode_q <= avs_writedata_in[2];
        scan_last_q <= avs_writedata_in[4:3];
      end
    end
  end
  // sequencer; start ignored while busy
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= adcc_pkg::ADCC_IDLE;
      cnt_q <= 8'h00;
      ch_q <= '0;
      result_q <= '0;
    end else begin
      unique case (state_q)
        adcc_pkg::ADCC_IDLE: begin
          cnt_q <= 8'h00;
          ch_q <= '0;
          if (start) begin
            state_q <= adcc_pkg::ADCC_CONV;
          end
        end
        adcc_pkg::ADCC_CONV: begin
          cnt_q <= cnt_q + 8'h01;
          if (conv_done) begin
            result_q <= conv_sample_in; // [RL1]
            cnt_q <= 8'h00;
            state_q <= last_ch ? adcc_pkg::ADCC_IDLE : adcc_pkg::ADCC_NEXT;
          end
        end
        adcc_pkg::ADCC_NEXT: begin
          ch_q <= ch_q + 1'b1;
          state_q <= adcc_pkg::ADCC_CONV;
        end
        default: state_q <= adcc_pkg::ADCC_IDLE;
      endcase
    end
  end
  // end flag; set beats clear, arming needs a read of 1
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      conversion_end_flag_q <= 1'b0;
      flag_seen_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (end_set) begin
        conversion_end_flag_q <= 1'b1; // [RL3] [RL4]
      end else if (flag_clr) begin
        conversion_end_flag_q <= 1'b0; // [RL2]
      end
      if (end_set | flag_clr) begin
        flag_seen_q <= 1'b0;
      end else if (rd_status & conversion_end_flag_q) begin
        flag_seen_q <= 1'b1; // [RL2]
      end
      // same priority as the flag: a set in the clearing cycle keeps irq
      irq_q <= (end_set | (conversion_end_flag_q & ~flag_clr)) &
        irq_mask_q;
    end
  end
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign conv_channel_out = ch_q;
  assign irq_out = irq_q;

  a_flag_clear_armed: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(conversion_end_flag_q) |-> $past(flag_seen_q)) // [RL2]
    else $error("end flag cleared without prior read");
  a_no_set_by_write: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(conversion_end_flag_q) |-> $past(end_set)) // [RL5]
    else $error("end flag set without conversion end");
  a_single_sets: assert property (@(posedge clk_in) disable iff (rst_in)
    conv_done & ~scan_mode_q |=> conversion_end_flag_q) // [RL3]
    else $error("single conversion did not set end flag");
  a_scan_waits: assert property (@(posedge clk_in) disable iff (rst_in)
    conv_done & scan_mode_q & (ch_q != scan_last_q) & ~conversion_end_flag_q
    |=> ~conversion_end_flag_q) // [RL4]
    else $error("scan set end flag early");
  a_trig_gated: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == adcc_pkg::ADCC_IDLE) & trig_rise & ~external_trigger_enable_q
    & ~sw_start |=> state_q == adcc_pkg::ADCC_IDLE) // [RL6]
    else $error("disabled trigger started conversion");
  a_trig_starts: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == adcc_pkg::ADCC_IDLE) & hw_start
    |=> state_q == adcc_pkg::ADCC_CONV) // [RL6]
    else $error("enabled trigger did not start");
  a_ctrl_ones: assert property (@(posedge clk_in) disable iff (rst_in)
    ack_q & $past(avs_read_in) & ($past(avs_address_in) == `ADCC_OFF_CTRL)
    |-> avs_readdata_out[6:0] == 7'h7F) // [RL7]
    else $error("control unused bits not read as one");
  a_result_held: assert property (@(posedge clk_in) disable iff (rst_in)
    conv_done |=> result_q == $past(conv_sample_in)) // [RL1]
    else $error("result not captured");
  a_set_beats_clr: assert property ( // [RL3] [RL4]
    @(posedge clk_in) disable iff (rst_in)
    end_set |=> conversion_end_flag_q)
    else $error("end flag lost on set");
  a_clear_by_zero: assert property ( // [RL2]
    @(posedge clk_in) disable iff (rst_in)
    flag_clr & ~end_set |=> ~conversion_end_flag_q)
    else $error("armed zero write did not clear end flag");
  a_one_write_kept: assert property ( // [RL5]
    @(posedge clk_in) disable iff (rst_in)
    conversion_end_flag_q & wr_status & avs_writedata_in[`ADCC_ST_EOC]
    |=> conversion_end_flag_q)
    else $error("write of one changed end flag");
  a_result_stable: assert property ( // [RL1]
    @(posedge clk_in) disable iff (rst_in)
    ~conv_done |=> $stable(result_q))
    else $error("result changed outside conversion end");
  a_trig_en_write: assert property ( // [RL6]
    @(posedge clk_in) disable iff (rst_in)
    wr_ctrl |=> external_trigger_enable_q ==
      $past(avs_writedata_in[`ADCC_CTRL_EXT_TRIG]))
    else $error("trigger enable not written");
  a_seen_needs_read: assert property ( // [RL2]
    @(posedge clk_in) disable iff (rst_in)
    $rose(flag_seen_q) |-> $past(rd_status) & $past(conversion_end_flag_q))
    else $error("clear armed without a read of one");
endmodule

// file: tb/test_adcc_top.sv
// self-checking bench for the conversion control block
// assumes adcc_top, its defines header and a 50 ns clock
`timescale 1ns/1ps
`include "adcc_defines.svh"
module test_adcc_top;
  localparam int CC = 4;
  logic clk_in = 0;
  logic rst_in = 1;
  logic rd = 0;
  logic wr = 0;
  logic pin = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wq;
  logic irq;
  logic [9:0] smp = 10'h000;
  logic [9:0] s;
  logic [7:0] w;
  logic [`ADCC_CH_W-1:0] ch;
  logic [`ADCC_CH_W-1:0] ch_max = '0;
  int fail_count = 0;
  int samples_checked = 0;
  adcc_top #(.CONV_CYC(CC)) i_adcc_top (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq), .external_trigger_pin_in(pin),
    .conv_sample_in(smp), .conv_channel_out(ch), .irq_out(irq));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // highest channel visited, sampled away from the rising edge
  always @(negedge clk_in) begin
    if (ch > ch_max) begin
      ch_max <= ch;
    end
  end
  task final_report;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // request held until the edge where waitrequest is seen low
  task acc(input logic wn, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    rd <= !wn;
    wr <= wn;
    do begin
      @(posedge clk_in);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (wq !== 1'b0) begin
      fail_count++;
      final_report();
    end
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask
  task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (irq !== 1'b1) begin
      fail_count++;
      final_report();
    end
  endtask
  task pulse;
    @(posedge clk_in);
    pin <= 1;
    repeat (4) @(posedge clk_in);
    pin <= 0;
  endtask
  task clear_flag;
    acc(0, `ADCC_OFF_STATUS, 0);
    acc(1, `ADCC_OFF_STATUS, 0);
  endtask
  initial begin
    void'($urandom(32'h3d4e_93e5));
    repeat (6) @(posedge clk_in);
    rst_in <= 0;
    acc(0, `ADCC_OFF_CTRL, 0);
    chk(q[7:0], `ADCC_CTRL_RESET, "control reset");
    for (int i = 0; i < 4; i++) begin
      w = (i == 3) ? 8'($urandom) : 8'(i * 8'h40);
      acc(1, `ADCC_OFF_CTRL, {24'h00_0000, w});
      acc(0, `ADCC_OFF_CTRL, 0);
      chk(q[7:0], {w[7], 7'h7F}, "control bits");
    end
    acc(0, 4'h2, 0);
    chk(q, 32'h0000_0000, "unmapped read");
    acc(1, `ADCC_OFF_CTRL, 32'h0000_0000);
    pulse();
    repeat (CC + 12) @(negedge clk_in);
    acc(0, `ADCC_OFF_STATUS, 0);
    chk(q[0], 1'b0, "trigger ignored");
    s = 10'($urandom);
    smp <= s;
    acc(1, `ADCC_OFF_START, 32'h0000_0003);
    wait_irq();
    acc(0, `ADCC_OFF_RESULT, 0);
    chk(q[9:0], s, "single result");
    acc(1, `ADCC_OFF_STATUS, 0);
    acc(0, `ADCC_OFF_STATUS, 0);
    chk(q[0], 1'b1, "clear without read");
    acc(1, `ADCC_OFF_STATUS, 1);
    acc(0, `ADCC_OFF_STATUS, 0);
    chk(q[0], 1'b1, "write one");
    acc(1, `ADCC_OFF_STATUS, 0);
    acc(0, `ADCC_OFF_STATUS, 0);
    chk({q[0], irq}, 2'b00, "read then clear");
    acc(1, `ADCC_OFF_STATUS, 1);
    acc(0, `ADCC_OFF_STATUS, 0);
    chk(q[0], 1'b0, "write one when clear");
    acc(1, `ADCC_OFF_CTRL, 32'h0000_0080);
    acc(1, `ADCC_OFF_START, 32'h0000_0002);
    s = 10'($urandom);
    smp <= s;
    pulse();
    wait_irq();
    acc(0, `ADCC_OFF_RESULT, 0);
    chk(q[9:0], s, "trigger result");
    clear_flag();
    // scan over channels 0..3, flag only after the last
    acc(1, `ADCC_OFF_START, 32'h0000_001F);
    repeat (2 * CC + 2) @(negedge clk_in);
    acc(0, `ADCC_OFF_STATUS, 0);
    chk({q[0], irq}, 2'b00, "scan early flag");
    wait_irq();
    acc(0, `ADCC_OFF_STATUS, 0);
    chk(q[0], 1'b1, "scan flag");
    chk(ch_max, 2'h3, "scan channels");
    acc(1, `ADCC_OFF_STATUS, 0);
    acc(1, `ADCC_OFF_START, 32'h0000_0001);
    repeat (CC + 12) @(negedge clk_in);
    chk(irq, 1'b0, "masked irq");
    acc(0, `ADCC_OFF_STATUS, 0);
    chk(q[0], 1'b1, "masked flag");
    final_report();
  end
endmodule
